/* File: inc/dci_pkg.sv */
/*
 Constants, types and states shared by the debug command interpreter.
 Assumes a byte-wide serial transceiver with auto-baud outside the block.
*/
// Function
// - Command byte, arguments, then ordered response bytes
// - Outside debug: only revision, status, control
// - Read protect disables PC, register read
// - 00H returns revision, major byte first
// - 02H returns one status byte
// - 16-bit runtime counter, saturates at FFFFH
// - 03H returns runtime counter, high first
// - Runtime counter valid only before data commands; runtime_ff restarts when a 04H write clears the debug bit
// - 04H takes one byte into control
// - Read protect: debug bit sets, never clears
// - 05H returns one control register byte
// - 06H loads PC, discarded when gated
// - 07H returns PC, or FFFFH when gated
// - Size zero means 256 data bytes
// - Register write outside debug: consume, discard
// - Read protect: only flash control writes apply
// - Read protect: flash command only mass erase
// - 09H reads 1 to 256 register bytes
// - Gated register read returns FFH bytes
// - Bytes framed 8N1.5 by external transceiver
// - Serial error aborts command, sends break
package dci_pkg;
   localparam logic [7:0] CMD_REV = 8'h00;
   localparam logic [7:0] CMD_STAT = 8'h02;
   localparam logic [7:0] CMD_RUNTIME = 8'h03;
   localparam logic [7:0] CMD_CTL_WR = 8'h04;
   localparam logic [7:0] CMD_CTL_RD = 8'h05;
   localparam logic [7:0] CMD_PC_WR = 8'h06;
   localparam logic [7:0] CMD_PC_RD = 8'h07;
   localparam logic [7:0] CMD_REG_WR = 8'h08;
   localparam logic [7:0] CMD_REG_RD = 8'h09;
   // Control register layout
   localparam int CTL_MODE_BIT = 7;
   localparam int CTL_BRKEN_BIT = 6;
   localparam int CTL_RST_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CTL_WR_MASK = 8'he1;
   localparam logic [7:0] ALL_ONES_BYTE = 8'hff;
   localparam logic [15:0] ALL_ONES_WORD = 16'hffff;
   localparam logic [15:0] RUNTIME_MAX = 16'hffff;
   localparam logic [8:0] BLOCK_MAX = 9'h100;
   // Revision value is arbitrary
   localparam logic [15:0] REVISION_DEFAULT = 16'h0100;
   // Flash control register window and mass erase code
   localparam logic [11:0] FLASH_CTL_FIRST = 12'hff8;
   localparam logic [11:0] FLASH_CTL_LAST = 12'hffb;
   localparam logic [11:0] FLASH_CMD_ADDR = 12'hff8;
   localparam logic [7:0] MASS_ERASE_CMD = 8'h63;
   localparam int RESP_FIFO_DEPTH = 16;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dci_rf_req_t;

   typedef enum logic [2:0] {
      S_CMD, S_ARG, S_WDATA, S_RESP, S_RREQ, S_RWAIT
   } dci_state_t;
endpackage : dci_pkg

/* File: src/dci_top.sv */
/*
 Debug command interpreter with its response FIFO.
 Assumes an external transceiver delivering received bytes and errors, and
 draining response bytes; register file reads return data combinationally.
*/
`timescale 1ns/100ps
`default_nettype none

module dci_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   // Full and empty from the occupancy count
   assign in_ready = (count_ff != (AW+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else if (flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
         end
         if (push && !pop) begin
            count_ff <= count_ff + (AW+1)'(1);
         end else if (pop && !push) begin
            count_ff <= count_ff - (AW+1)'(1);
         end
      end
   end
endmodule : dci_fifo

module dci_top
   import dci_pkg::*;
#(
   parameter logic [15:0] REVISION = REVISION_DEFAULT,
   parameter logic [11:0] FLASH_FIRST = FLASH_CTL_FIRST,
   parameter logic [11:0] FLASH_LAST = FLASH_CTL_LAST,
   parameter logic [11:0] FLASH_CMD = FLASH_CMD_ADDR,
   parameter logic [7:0] MASS_ERASE = MASS_ERASE_CMD,
   parameter int FIFO_DEPTH = RESP_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_error,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_break,
   input wire logic read_protect_option,
   input wire logic halt_state,
   input wire logic brk_event,
   input wire logic sys_reset_done,
   output logic halt_debug_state_bit,
   output logic sys_reset_req,
   input wire logic [15:0] pc_value,
   output logic pc_load,
   output logic [15:0] pc_load_value,
   output dci_rf_req_t rf_req,
   input wire logic [7:0] rf_rdata
);
   logic rst_meta_ff;
   logic rst_n_ff;
   dci_state_t state_ff;
   logic [7:0] cmd_ff;
   logic [7:0] arg0_ff;
   logic [7:0] arg1_ff;
   logic [1:0] arg_idx_ff;
   logic [1:0] arg_need_ff;
   logic [15:0] resp_ff;
   logic [1:0] resp_cnt_ff;
   logic [8:0] rem_ff;
   logic [11:0] addr_ff;
   logic [7:0] ctl_ff;
   logic [15:0] runtime_ff;
   logic dbg_prev_ff;
   logic tx_break_ff;
   logic pc_load_ff;
   logic [15:0] pc_load_value_ff;
   dci_rf_req_t rf_req_ff;
   dci_rf_req_t nxt_rf_req;
   logic [7:0] nxt_ctl;
   logic dbg;
   logic priv_ok;
   logic arg_last;
   logic push_valid;
   logic push_ready;
   logic [7:0] push_data;
   logic in_flash;
   logic wr_allowed;
   logic [7:0] status;

   // Reset release through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   assign dbg = ctl_ff[CTL_MODE_BIT];
   assign priv_ok = dbg & ~read_protect_option;
   assign status = {dbg, halt_state, read_protect_option, 5'h00};
   assign arg_last = (state_ff == S_ARG) && rx_valid && (arg_idx_ff == arg_need_ff);
   assign rx_ready = (state_ff == S_CMD) || (state_ff == S_ARG) || (state_ff == S_WDATA);
   assign halt_debug_state_bit = dbg;
   assign sys_reset_req = ctl_ff[CTL_RST_BIT];
   assign tx_break = tx_break_ff;
   assign pc_load = pc_load_ff;
   assign pc_load_value = pc_load_value_ff;
   assign rf_req = rf_req_ff;

   // Flash window checks for protected register writes
   assign in_flash = (addr_ff >= FLASH_FIRST) && (addr_ff <= FLASH_LAST);
   always_comb begin
      wr_allowed = 1'b0;
      if (dbg && !read_protect_option) begin
         wr_allowed = 1'b1;
      end else if (dbg && in_flash) begin
         wr_allowed = (addr_ff != FLASH_CMD) || (rx_data == MASS_ERASE);
      end
   end

   // Response byte source for the FIFO
   always_comb begin
      push_valid = 1'b0;
      push_data = ALL_ONES_BYTE;
      if (state_ff == S_RESP) begin
         push_valid = 1'b1;
         push_data = (resp_cnt_ff == 2'd2) ? resp_ff[15:8] : resp_ff[7:0];
      end else if (state_ff == S_RREQ && !priv_ok) begin
         push_valid = 1'b1;
      end else if (state_ff == S_RWAIT) begin
         push_valid = 1'b1;
         push_data = rf_rdata;
      end
   end

   // Command sequencer
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         state_ff <= S_CMD;
         cmd_ff <= 8'h00;
         arg0_ff <= 8'h00;
         arg1_ff <= 8'h00;
         arg_idx_ff <= 2'd0;
         arg_need_ff <= 2'd0;
         resp_ff <= 16'h0000;
         resp_cnt_ff <= 2'd0;
         rem_ff <= 9'h000;
         addr_ff <= 12'h000;
      end else if (rx_error) begin
         state_ff <= S_CMD;
      end else begin
         case (state_ff)
            S_CMD: begin
               if (rx_valid) begin
                  cmd_ff <= rx_data;
                  arg_idx_ff <= 2'd0;
                  resp_cnt_ff <= 2'd2;
                  if (rx_data == CMD_REV) begin
                     resp_ff <= REVISION;
                     state_ff <= S_RESP;
                  end else if (rx_data == CMD_STAT) begin
                     resp_ff <= {8'h00, status};
                     resp_cnt_ff <= 2'd1;
                     state_ff <= S_RESP;
                  end else if (rx_data == CMD_RUNTIME) begin
                     resp_ff <= dbg ? runtime_ff : ALL_ONES_WORD;
                     state_ff <= S_RESP;
                  end else if (rx_data == CMD_CTL_RD) begin
                     resp_ff <= {8'h00, ctl_ff};
                     resp_cnt_ff <= 2'd1;
                     state_ff <= S_RESP;
                  end else if (rx_data == CMD_PC_RD) begin
                     resp_ff <= priv_ok ? pc_value : ALL_ONES_WORD;
                     state_ff <= S_RESP;
                  end else if (rx_data == CMD_CTL_WR) begin
                     arg_need_ff <= 2'd0;
                     state_ff <= S_ARG;
                  end else if (rx_data == CMD_PC_WR) begin
                     arg_need_ff <= 2'd1;
                     state_ff <= S_ARG;
                  end else if (rx_data == CMD_REG_WR || rx_data == CMD_REG_RD) begin
                     arg_need_ff <= 2'd2;
                     state_ff <= S_ARG;
                  end
                  // Other codes leave the sequencer waiting
               end
            end
            S_ARG: begin
               if (rx_valid) begin
                  arg_idx_ff <= arg_idx_ff + 2'd1;
                  if (arg_idx_ff == 2'd0) begin
                     arg0_ff <= rx_data;
                  end else if (arg_idx_ff == 2'd1) begin
                     arg1_ff <= rx_data;
                  end
                  if (arg_last) begin
                     addr_ff <= {arg0_ff[3:0], arg1_ff};
                     rem_ff <= (rx_data == 8'h00) ? BLOCK_MAX : {1'b0, rx_data};
                     if (cmd_ff == CMD_REG_WR) begin
                        state_ff <= S_WDATA;
                     end else if (cmd_ff == CMD_REG_RD) begin
                        state_ff <= S_RREQ;
                     end else begin
                        state_ff <= S_CMD;
                     end
                  end
               end
            end
            S_WDATA: begin
               if (rx_valid) begin
                  addr_ff <= addr_ff + 12'h001;
                  rem_ff <= rem_ff - 9'h001;
                  if (rem_ff == 9'h001) begin
                     state_ff <= S_CMD;
                  end
               end
            end
            S_RESP: begin
               if (push_ready) begin
                  resp_cnt_ff <= resp_cnt_ff - 2'd1;
                  if (resp_cnt_ff == 2'd1) begin
                     state_ff <= S_CMD;
                  end
               end
            end
            S_RREQ: begin
               if (push_ready && priv_ok) begin
                  state_ff <= S_RWAIT;
               end else if (push_ready) begin
                  addr_ff <= addr_ff + 12'h001;
                  rem_ff <= rem_ff - 9'h001;
                  if (rem_ff == 9'h001) begin
                     state_ff <= S_CMD;
                  end
               end
            end
            S_RWAIT: begin
               addr_ff <= addr_ff + 12'h001;
               rem_ff <= rem_ff - 9'h001;
               state_ff <= (rem_ff == 9'h001) ? S_CMD : S_RREQ;
            end
            default: state_ff <= S_CMD;
         endcase
      end
   end

   // Control register write value
   always_comb begin
      nxt_ctl = ctl_ff;
      if (arg_last && cmd_ff == CMD_CTL_WR && !rx_error) begin
         nxt_ctl = rx_data & CTL_WR_MASK;
         nxt_ctl[CTL_MODE_BIT] = rx_data[CTL_MODE_BIT] | (read_protect_option & dbg);
      end else if (sys_reset_done) begin
         nxt_ctl[CTL_RST_BIT] = 1'b0;
      end
      if (brk_event && ctl_ff[CTL_BRKEN_BIT]) begin
         nxt_ctl[CTL_MODE_BIT] = 1'b1;
      end
   end

   // Control register, survives serial errors
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         ctl_ff <= CTL_RESET;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // Runtime counter: restarts on leaving debug, frozen inside
   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         runtime_ff <= 16'h0000;
         dbg_prev_ff <= 1'b0;
      end else begin
         dbg_prev_ff <= dbg;
         if (dbg_prev_ff && !dbg) begin
            runtime_ff <= 16'h0000;
         end else if (!dbg && runtime_ff != RUNTIME_MAX) begin
            runtime_ff <= runtime_ff + 16'h0001;
         end
      end
   end

   // Register file request, write gating and PC load
   always_comb begin
      nxt_rf_req.wr = (state_ff == S_WDATA) && rx_valid && wr_allowed && !rx_error;
      nxt_rf_req.rd = (state_ff == S_RREQ) && priv_ok && push_ready && !rx_error;
      nxt_rf_req.addr = addr_ff;
      nxt_rf_req.wdata = rx_data;
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rf_req_ff <= '0;
         pc_load_ff <= 1'b0;
         pc_load_value_ff <= 16'h0000;
         tx_break_ff <= 1'b0;
      end else begin
         rf_req_ff <= nxt_rf_req;
         pc_load_ff <= arg_last && (cmd_ff == CMD_PC_WR) && priv_ok && !rx_error;
         if (arg_last && cmd_ff == CMD_PC_WR) begin
            pc_load_value_ff <= {arg0_ff, rx_data};
         end
         tx_break_ff <= rx_error;
      end
   end

   // Response FIFO; a full FIFO stalls the sequencer
   dci_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_resp_fifo (
      .clk(clk),
      .rst_n(rst_n_ff),
      .flush(rx_error),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
endmodule : dci_top

`default_nettype wire

/* File: tb/dci_props.sv */
/*
 Port checker for the debug command interpreter.
 Assumes it is bound to dci_top; one clock, resetn low resets.
*/
`timescale 1ns/100ps
`default_nettype none
module dci_props
   import dci_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_ready,
   input wire logic rx_error,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_break,
   input wire logic read_protect_option,
   input wire logic halt_debug_state_bit,
   input wire logic pc_load,
   input wire dci_rf_req_t rf_req
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // Abort: break back, queue flushed, ready for a command
   sequence s_after_abort;
      tx_break && !tx_valid && rx_ready;
   endsequence
   property p_abort;
      rx_error |=> s_after_abort;
   endproperty
   a_abort: assert property (p_abort) else $error("abort missing");
   property p_break_cause;
      tx_break |-> $past(rx_error);
   endproperty
   a_break_cause: assert property (p_break_cause) else $error("stray break");
   property p_pc_gate;
      pc_load |-> $past(halt_debug_state_bit) && !$past(read_protect_option);
   endproperty
   a_pc_gate: assert property (p_pc_gate) else $error("gated pc load");
   property p_wr_debug;
      rf_req.wr |-> $past(halt_debug_state_bit);
   endproperty
   a_wr_debug: assert property (p_wr_debug) else $error("write outside debug");
   property p_wr_flash;
      rf_req.wr && read_protect_option |-> rf_req.addr >= FLASH_CTL_FIRST
         && rf_req.addr <= FLASH_CTL_LAST;
   endproperty
   a_wr_flash: assert property (p_wr_flash) else $error("protected write");
   property p_wr_erase;
      rf_req.wr && read_protect_option && rf_req.addr == FLASH_CMD_ADDR
         |-> rf_req.wdata == MASS_ERASE_CMD;
   endproperty
   a_wr_erase: assert property (p_wr_erase) else $error("flash command");
   property p_rd_gate;
      rf_req.rd |-> $past(halt_debug_state_bit) && !$past(read_protect_option);
   endproperty
   a_rd_gate: assert property (p_rd_gate) else $error("gated read");
   property p_mode_hold;
      read_protect_option && halt_debug_state_bit |=> halt_debug_state_bit;
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("debug cleared");
   property p_tx_hold;
      tx_valid && !tx_ready && !rx_error |=> tx_valid && $stable(tx_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("byte lost");
endmodule : dci_props
`default_nettype wire

/* File: tb/dci_host.sv */
/*
 Host side model: offers command bytes and drains response bytes.
 Assumes the bench calls send and idle; slow stalls draining.
*/
`timescale 1ns/100ps
`default_nettype none
module dci_host (
   input wire logic clk,
   input wire logic slow,
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got[$];
   logic [1:0] ph = 2'h0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
   end
   // Offer one byte and hold it until taken
   task automatic send(input logic [7:0] b);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = b;
      do @(posedge clk); while (!rx_ready);
   endtask : send
   // Release; data shows the inverse of the last byte
   task automatic idle();
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask : idle
   // Slow mode takes one byte in four
   always @(negedge clk) begin
      ph <= ph + 2'h1;
      tx_ready <= !slow || ph == 2'h3;
   end
   // Collect responses in order
   always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
endmodule : dci_host
`default_nettype wire

/* File: tb/test_debug_command_interpreter.sv */
/*
 Self-checking bench for the debug command interpreter.
 Assumes a host model on the byte ports and a register file model here.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_debug_command_interpreter
   import dci_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0, rx_valid, rx_ready, rx_error = 1'b0, tx_valid, tx_ready;
   logic tx_break, rp = 1'b0, sys_reset_done = 1'b0, dbg, sys_reset_req, pc_load, slow = 1'b0;
   logic halt = 1'b1, brk = 1'b0;
   logic [7:0] rx_data, tx_data, rf_rdata;
   logic [15:0] pc_load_value, pcl_v;
   dci_rf_req_t rf_req;
   logic [19:0] wlog[$];
   int err_total = 0, check_count = 0, cyc = 0, pcl_n = 0;
   always #2.5 clk = ~clk;
   // Register file answers with a pattern of the address
   assign rf_rdata = rf_req.addr[7:0] ^ 8'h5a;
   dci_top dut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .rx_error(rx_error), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_break(tx_break), .read_protect_option(rp), .halt_state(halt),
      .brk_event(brk), .sys_reset_done(sys_reset_done), .halt_debug_state_bit(dbg),
      .sys_reset_req(sys_reset_req), .pc_value(16'h1234), .pc_load(pc_load),
      .pc_load_value(pc_load_value), .rf_req(rf_req), .rf_rdata(rf_rdata));
   dci_host host (.clk(clk), .slow(slow), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // Log register writes and program counter loads
   always @(posedge clk) begin
      cyc++;
      if (rf_req.wr) wlog.push_back({rf_req.addr, rf_req.wdata});
      if (pc_load) begin
         pcl_n++;
         pcl_v = pc_load_value;
      end
      if (cyc == 20000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic do_reset();
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
   endtask : do_reset
   task automatic cmd(input logic [7:0] b[$]);
      foreach (b[i]) host.send(b[i]);
      host.idle();
      repeat (2) @(posedge clk);
   endtask : cmd
   // Compare the next response bytes, waiting a bounded time for each
   task automatic expect_bytes(input string nm, input logic [7:0] e[$]);
      logic [7:0] g;
      foreach (e[i]) begin
         g = 8'hxx;
         for (int n = 0; n < 4000 && host.got.size() == 0; n++) @(posedge clk);
         if (host.got.size() != 0) g = host.got.pop_front();
         `CHK(nm, e[i], g)
      end
   endtask : expect_bytes
   task automatic silent();
      repeat (20) @(posedge clk);
      `CHK("no reply", 32'd0, host.got.size())
   endtask : silent
   task automatic t_normal();
      cmd('{8'h80});
      cmd('{CMD_REV});
      expect_bytes("revision", '{REVISION_DEFAULT[15:8], REVISION_DEFAULT[7:0]});
      cmd('{CMD_STAT});
      expect_bytes("status", '{8'h40});
      cmd('{CMD_PC_RD});
      expect_bytes("pc gated", '{8'hff, 8'hff});
      cmd('{CMD_REG_RD, 8'h00, 8'h10, 8'h02});
      expect_bytes("reg gated", '{8'hff, 8'hff});
      cmd('{CMD_RUNTIME});
      expect_bytes("runtime gated", '{8'hff, 8'hff});
      cmd('{CMD_PC_WR, 8'h12, 8'h34});
      `CHK("pc load gated", 0, pcl_n)
      silent();
      $display("done t_normal");
   endtask : t_normal
   task automatic t_ctl();
      cmd('{CMD_CTL_WR, 8'hc5});
      cmd('{CMD_CTL_RD});
      expect_bytes("control", '{8'hc1});
      `CHK("reset req", 1'b1, sys_reset_req)
      @(negedge clk) sys_reset_done = 1'b1;
      @(negedge clk) sys_reset_done = 1'b0;
      cmd('{CMD_CTL_RD});
      expect_bytes("control", '{8'hc0});
      $display("done t_ctl");
   endtask : t_ctl
   task automatic t_debug();
      logic [7:0] e[$];
      // Leave debug, run 101 counted cycles, re-enter by breakpoint
      cmd('{CMD_CTL_WR, 8'h40});
      repeat (99) @(posedge clk);
      @(negedge clk) brk = 1'b1;
      @(negedge clk) brk = 1'b0;
      halt = 1'b0;
      cmd('{CMD_RUNTIME});
      expect_bytes("runtime", '{8'h00, 8'h65});
      cmd('{CMD_STAT});
      expect_bytes("status debug", '{8'h80});
      cmd('{CMD_PC_RD});
      expect_bytes("pc", '{8'h12, 8'h34});
      cmd('{CMD_PC_WR, 8'hab, 8'hcd});
      `CHK("pc value", 16'habcd, pcl_v)
      cmd('{CMD_REG_WR, 8'h01, 8'h23, 8'h02, 8'hd0, 8'hd1});
      `CHK("wr0", 20'h123d0, wlog[0])
      `CHK("wr1", 20'h124d1, wlog[1])
      cmd('{CMD_REG_RD, 8'h01, 8'hfe, 8'h03});
      expect_bytes("read", '{8'ha4, 8'ha5, 8'h5a});
      for (int i = 0; i < 256; i++) e.push_back(i[7:0] ^ 8'h5a);
      slow = 1'b1;
      cmd('{CMD_REG_RD, 8'h00, 8'h00, 8'h00});
      expect_bytes("read 256", e);
      silent();
      $display("done t_debug");
   endtask : t_debug
   task automatic t_abort();
      cmd('{CMD_REG_RD, 8'h00, 8'h00, 8'h00});
      repeat (30) @(posedge clk);
      @(negedge clk) rx_error = 1'b1;
      @(negedge clk) rx_error = 1'b0;
      repeat (5) @(posedge clk);
      host.got.delete();
      silent();
      slow = 1'b0;
      cmd('{8'h80});
      cmd('{CMD_REV});
      expect_bytes("after abort", '{REVISION_DEFAULT[15:8], REVISION_DEFAULT[7:0]});
      `CHK("mode kept", 1'b1, dbg)
      $display("done t_abort");
   endtask : t_abort
   task automatic t_protect();
      @(negedge clk) rp = 1'b1;
      cmd('{CMD_PC_RD});
      expect_bytes("pc protected", '{8'hff, 8'hff});
      cmd('{CMD_CTL_WR, 8'h00});
      cmd('{CMD_CTL_RD});
      expect_bytes("mode held", '{8'h80});
      wlog.delete();
      cmd('{CMD_REG_WR, 8'h0f, 8'hf8, 8'h02, MASS_ERASE_CMD, 8'h11});
      cmd('{CMD_REG_WR, 8'h0f, 8'hf8, 8'h01, 8'h12});
      cmd('{CMD_REG_WR, 8'h00, 8'h10, 8'h01, 8'h55});
      `CHK("flash wr0", {FLASH_CMD_ADDR, MASS_ERASE_CMD}, wlog[0])
      `CHK("flash wr1", 20'hff911, wlog[1])
      `CHK("wr count", 32'd2, wlog.size())
      cmd('{CMD_REG_RD, 8'h0f, 8'hf8, 8'h01});
      expect_bytes("reg protected", '{8'hff});
      cmd('{CMD_PC_WR, 8'h00, 8'h01});
      `CHK("pc protected", 1, pcl_n)
      $display("done t_protect");
   endtask : t_protect
   task automatic t_outside();
      @(negedge clk) rp = 1'b0;
      do_reset();
      `CHK("normal mode", 1'b0, dbg)
      wlog.delete();
      cmd('{CMD_REG_WR, 8'h00, 8'h10, 8'h01, 8'h00});
      `CHK("discard", 32'd0, wlog.size())
      silent();
      $display("done t_outside");
   endtask : t_outside
   initial begin
      do_reset();
      t_normal();
      t_ctl();
      t_debug();
      t_abort();
      t_protect();
      t_outside();
      wrap_up();
   end
endmodule : test_debug_command_interpreter
bind dci_top dci_props u_props (.clk(clk), .resetn(resetn), .rx_ready(rx_ready),
   .rx_error(rx_error), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
   .tx_break(tx_break), .read_protect_option(read_protect_option),
   .halt_debug_state_bit(halt_debug_state_bit), .pc_load(pc_load), .rf_req(rf_req));
`default_nettype wire
